// *** psq_host.sv ***
// Host model making the serial bit clock and frame sync
`timescale 1ns/100ps
module psq_host (
	// Control from the bench
	input wire logic run,
	input wire logic no_bit,
	// Serial clocks toward the device
	output logic bit_clock,
	output logic frame_sync
);
	int half = 0; // Half periods run so far
	initial begin
		bit_clock = 1'b0;
		frame_sync = 1'b0;
	end
	// 64 ns bit clock, frame every 8 bits; both stand low when stopped
	always begin
		#32;
		if (run) begin
			half++;
			if (!no_bit) bit_clock = ~bit_clock; // Held bit clock forces a clock error
			if (half % 8 == 0) frame_sync = ~frame_sync;
		end else begin
			bit_clock = 1'b0;
			frame_sync = 1'b0;
		end
	end
endmodule : psq_host

// *** psq_pkg.sv ***
// Package of constants and types for the pin-mode power sequencer
package psq_pkg;
	// Clock rate and timing figures
	localparam int CLK_MHZ = 250;
	localparam int INIT_TIME_US = 2000;
	localparam int INIT_CYCLES = INIT_TIME_US * CLK_MHZ;
	localparam int WDOG_TIME_US = 200;
	localparam int WDOG_CYCLES = WDOG_TIME_US * CLK_MHZ;
	localparam int RAMP_STEP_NS = 400;
	localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS * CLK_MHZ + 999) / 1000;
	// Filter coefficient shifts: 2^-13 near 1Hz, 2^-9 near 12Hz at 48kHz
	localparam int HPF_SHIFT_1HZ = 13;
	localparam int HPF_SHIFT_12HZ = 9;
	// Low-latency group delay at 192kHz, in tenths of a sample
	localparam logic [31:0] LL_DELAY_TENTHS = 32'h0000_0044;
	// Register byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_MODE = 8'h08;
	localparam logic [7:0] REG_LATENCY = 8'h0C;
	// Reset values and field positions
	localparam logic CTRL_RESET = 1'b0;
	localparam int ST_IRQ_BIT = 3;
	localparam int ST_STOP_BIT = 4;
	localparam int ST_ERR_BIT = 5;
	localparam int ST_PWR_BIT = 6;
	localparam logic [8:0] GAIN_FULL = 9'h100;
	localparam logic [8:0] GAIN_ZERO = 9'h000;
	// Sequencer states, Gray from OFF up to RAMP; RAMP to SLEEP flips two bits
	typedef enum logic [2:0] {
		PSQ_OFF = 3'b000,
		PSQ_INIT = 3'b001,
		PSQ_SLEEP = 3'b011,
		PSQ_ACTIVE = 3'b010,
		PSQ_RAMP = 3'b110
	} psq_state_t;
	// Latched configuration pins
	typedef struct packed {
		logic serial_format_select_pin;
		logic [5:0] mode_cfg;
	} psq_mode_t;
	// One stereo sample pair
	typedef struct packed {
		logic [23:0] left;
		logic [23:0] right;
	} psq_pair_t;
endpackage : psq_pkg

// *** psq_sequencer.sv ***
// Pin-mode power sequencer with DC-removal filter and AHB-Lite status port
`timescale 1ns/100ps
module psq_sequencer import psq_pkg::*; #(
	parameter int INIT_CNT = INIT_CYCLES,
	parameter int WDOG_CNT = WDOG_CYCLES,
	parameter int STEP_CNT = RAMP_STEP_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Supplies and mode pins, asynchronous
	input wire logic analog_supply,
	input wire logic io_supply,
	input wire logic serial_format_select_pin,
	input wire logic mode_config_pin_a,
	input wire logic mode_config_pin_b,
	input wire logic mode_config_pin_c,
	input wire logic mode_config_pin_d,
	input wire logic mode_config_pin_e,
	input wire logic mode_config_pin_f,
	// Serial clocks from the host, asynchronous
	input wire logic bit_clock,
	input wire logic frame_sync,
	// Modulator samples, same clock domain
	input wire logic sample_in_valid,
	input wire psq_pair_t sample_in,
	// Filtered samples toward the serial interface, channel power flag and interrupt pin
	output logic sample_out_valid,
	output psq_pair_t sample_out,
	output logic adc_power_on,
	output logic general_output_pin,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp
);
	localparam int NSYNC = 11;

	// Synchroniser stages and the stable copy
	logic [NSYNC-1:0] sync_a;
	logic [NSYNC-1:0] sync_b;
	wire logic [NSYNC-1:0] raw_in = {analog_supply, io_supply, serial_format_select_pin,
		mode_config_pin_a, mode_config_pin_b, mode_config_pin_c, mode_config_pin_d,
		mode_config_pin_e, mode_config_pin_f, bit_clock, frame_sync};

	// Two flops per pin; only the second stage is read by logic
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge clock) begin
				if (!rstn) begin
					sync_a[gi] <= 1'b0;
					sync_b[gi] <= 1'b0;
				end else begin
					sync_a[gi] <= raw_in[gi];
					sync_b[gi] <= sync_a[gi];
				end
			end
		end
	endgenerate

	// Named views of the synchronised pins
	wire logic sup_ok = sync_b[10] & sync_b[9]; // Either order of rise is fine
	wire psq_mode_t pins_now = sync_b[8:2];
	wire logic bclk_s = sync_b[1];
	wire logic frame_sync_s = sync_b[0];

	// Edge detection history for the serial clocks
	logic bclk_d;
	logic frame_sync_d;
	wire logic bclk_edge = bclk_s & ~bclk_d;
	wire logic frame_sync_edge = frame_sync_s & ~frame_sync_d;

	// Sequencer state and counters
	psq_state_t state;
	psq_state_t next_state;
	logic [31:0] init_cnt;
	logic [31:0] wdog_cnt;
	logic [31:0] step_cnt;
	logic [8:0] gain;
	logic seen_bclk; // Bit clock edge since last frame edge
	logic seen_frame_sync; // Frame edge seen since the watchdog last fired
	logic irq_latch;
	logic stop_evt;
	logic err_evt;
	psq_mode_t mode_lat;
	logic hpf_sel; // Software asks for the 12Hz corner

	// Watchdog: no edges for the window means the clocks stopped
	wire logic wdog_hit = (wdog_cnt >= 32'(WDOG_CNT));
	// Frame edge with no bit clock edge in the frame is a clock error
	wire logic clk_err = frame_sync_edge & ~seen_bclk & seen_frame_sync;
	// Both clocks running wakes the part
	wire logic clocks_ok = seen_frame_sync & seen_bclk & ~wdog_hit;
	wire logic in_active = (state == PSQ_ACTIVE);
	wire logic clk_lost = in_active & (wdog_hit | clk_err);

	// Next-state decode of the power sequence
	always_comb begin
		next_state = state;
		unique case (state)
			PSQ_OFF: begin
				if (sup_ok) begin
					next_state = PSQ_INIT; // Wakes with no enable input
				end
			end
			PSQ_INIT: begin
				if (init_cnt >= 32'(INIT_CNT)) begin
					next_state = PSQ_SLEEP; // Low power until clocks come
				end
			end
			PSQ_SLEEP: begin
				if (clocks_ok) begin
					next_state = PSQ_ACTIVE;
				end
			end
			PSQ_ACTIVE: begin
				if (clk_lost) begin
					next_state = PSQ_RAMP; // Channels go down on their own
				end
			end
			PSQ_RAMP: begin
				if (gain == GAIN_ZERO) begin
					next_state = PSQ_SLEEP; // Ramp done, blocks off
				end
			end
			default: next_state = PSQ_OFF;
		endcase
	end

	// Supply loss is the only way back to OFF; it acts as the power cycle
	always_ff @(posedge clock) begin
		if (!rstn) begin
			state <= PSQ_OFF;
		end else if (!sup_ok) begin
			state <= PSQ_OFF;
		end else begin
			state <= next_state;
		end
	end

	// Initialization timer runs only in INIT
	always_ff @(posedge clock) begin
		if (!rstn || state != PSQ_INIT) begin
			init_cnt <= 32'h0000_0000;
		end else begin
			init_cnt <= init_cnt + 32'h0000_0001;
		end
	end

	// Clock edge history and watchdog counter
	always_ff @(posedge clock) begin
		if (!rstn || !sup_ok) begin
			bclk_d <= 1'b0;
			frame_sync_d <= 1'b0;
			wdog_cnt <= 32'h0000_0000;
			seen_bclk <= 1'b0;
			seen_frame_sync <= 1'b0;
		end else begin
			bclk_d <= bclk_s;
			frame_sync_d <= frame_sync_s;
			// An edge on either clock holds the watchdog off
			if (bclk_edge | frame_sync_edge) begin
				wdog_cnt <= 32'h0000_0000;
			end else if (!wdog_hit) begin
				wdog_cnt <= wdog_cnt + 32'h0000_0001;
			end
			if (wdog_hit) begin
				seen_bclk <= 1'b0; // Start over once stopped
				seen_frame_sync <= 1'b0;
			end else if (frame_sync_edge) begin
				seen_frame_sync <= 1'b1;
				seen_bclk <= bclk_edge;
			end else if (bclk_edge) begin
				seen_bclk <= 1'b1;
			end
		end
	end

	// Sticky clock events; only a supply cycle clears them
	always_ff @(posedge clock) begin
		if (!rstn || !sup_ok) begin
			irq_latch <= 1'b0;
			stop_evt <= 1'b0;
			err_evt <= 1'b0;
		end else begin
			if (clk_lost) begin
				irq_latch <= 1'b1;
			end
			if (in_active & wdog_hit) begin
				stop_evt <= 1'b1;
			end
			if (in_active & clk_err) begin
				err_evt <= 1'b1;
			end
		end
	end

	// Format pin caught as supplies settle, other pins at wake-up
	always_ff @(posedge clock) begin
		if (!rstn) begin
			mode_lat <= '0;
		end else begin
			if (state == PSQ_OFF && sup_ok) begin
				mode_lat.serial_format_select_pin <= pins_now.serial_format_select_pin;
			end
			// Host must have settled them before clocks; we sample at wake
			if (state == PSQ_SLEEP && clocks_ok) begin
				mode_lat.mode_cfg <= pins_now.mode_cfg;
			end
		end
	end

	// Volume ramp: full at wake, one step down per interval on power-down
	always_ff @(posedge clock) begin
		if (!rstn || !sup_ok) begin
			gain <= GAIN_ZERO;
			step_cnt <= 32'h0000_0000;
		end else if (state == PSQ_SLEEP && clocks_ok) begin
			gain <= GAIN_FULL;
			step_cnt <= 32'h0000_0000;
		end else if (state == PSQ_RAMP && gain != GAIN_ZERO) begin
			if (step_cnt >= 32'(STEP_CNT - 1)) begin
				step_cnt <= 32'h0000_0000;
				gain <= gain - 9'h001;
			end else begin
				step_cnt <= step_cnt + 32'h0000_0001;
			end
		end
	end

	// Format 1 with cfg a low is target I2S/LJ; only then is 12Hz allowed
	wire logic target_i2s_lj = mode_lat.serial_format_select_pin & ~mode_lat.mode_cfg[5];
	wire logic use_12hz = hpf_sel & target_i2s_lj;
	// One shift for every channel; 1Hz when nothing else selected
	wire logic [4:0] hpf_shift = use_12hz ? 5'(HPF_SHIFT_12HZ) : 5'(HPF_SHIFT_1HZ);
	wire logic run = (state == PSQ_ACTIVE) | (state == PSQ_RAMP);
	logic [47:0] filt_out;

	// First-order IIR high-pass per channel: y = x - x1 + y1 - y1*2^-k
	generate
		for (gi = 0; gi < 2; gi++) begin : g_hpf
			logic signed [31:0] x1;
			logic signed [31:0] y1;
			wire logic signed [31:0] xin = 32'(signed'(sample_in[24*gi +: 24]));
			wire logic signed [31:0] ynew = xin - x1 + y1 - (y1 >>> hpf_shift);
			wire logic sat_hi = (ynew > 32'sh007F_FFFF);
			wire logic sat_lo = (ynew < -32'sh0080_0000);
			wire logic signed [23:0] ysat = sat_hi ? 24'sh7F_FFFF :
				(sat_lo ? -24'sh80_0000 : ynew[23:0]);
			// Gain applied after the filter so the ramp does not disturb it
			wire logic signed [33:0] prod = 34'(ysat * $signed({1'b0, gain}));
			// Filter history clears while channels are down
			always_ff @(posedge clock) begin
				if (!rstn || !run) begin
					x1 <= 32'sh0000_0000;
					y1 <= 32'sh0000_0000;
				end else if (sample_in_valid) begin
					x1 <= xin;
					y1 <= ynew;
				end
			end
			assign filt_out[24*gi +: 24] = prod[31:8];
		end
	endgenerate

	// Output samples registered, sent only while channels are up
	always_ff @(posedge clock) begin
		if (!rstn) begin
			sample_out <= '0;
			sample_out_valid <= 1'b0;
			adc_power_on <= 1'b0;
			general_output_pin <= 1'b0;
		end else begin
			sample_out_valid <= run & sample_in_valid;
			if (run & sample_in_valid) begin
				sample_out <= filt_out;
			end
			adc_power_on <= run; // Off again once the ramp ends
			general_output_pin <= irq_latch;
		end
	end

	// AHB-Lite address phase capture
	logic wr_pend;
	logic [7:0] wr_addr;
	wire logic ahb_go = hsel & htrans[1] & hready;
	wire logic [7:0] a_off = haddr[7:0];

	// Read mux built from the address phase
	wire logic [31:0] st_word = {25'h0, adc_power_on, err_evt, stop_evt, irq_latch, state};
	wire logic [31:0] rd_mux = (a_off == REG_CTRL) ? {31'h0, hpf_sel} :
		(a_off == REG_STATUS) ? st_word :
		(a_off == REG_MODE) ? {25'h0, mode_lat} :
		(a_off == REG_LATENCY) ? LL_DELAY_TENTHS : 32'h0000_0000;

	// Zero wait state, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Bus slave: read data loaded in the address phase, write done in data phase
	always_ff @(posedge clock) begin
		if (!rstn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
			hpf_sel <= CTRL_RESET; // 1Hz after reset
		end else begin
			wr_pend <= ahb_go & hwrite;
			if (ahb_go) begin
				wr_addr <= a_off;
				hrdata <= hwrite ? 32'h0000_0000 : rd_mux;
			end
			if (wr_pend && wr_addr == REG_CTRL) begin
				hpf_sel <= hwdata[0];
			end
		end
	end
endmodule : psq_sequencer

// *** psq_sequencer_chk.sv ***
// Port checker for the power sequencer, bound to its top module
`timescale 1ns/100ps
module psq_sequencer_chk import psq_pkg::*; #(
	parameter int STEP_CNT = RAMP_STEP_CYCLES
) (
	// Clock, reset, supplies
	input wire logic clock,
	input wire logic rstn,
	input wire logic analog_supply,
	input wire logic io_supply,
	// Samples and pins
	input wire logic sample_in_valid,
	input wire logic sample_out_valid,
	input wire logic adc_power_on,
	input wire logic general_output_pin,
	// Register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp
);
	// Whole ramp plus sync slack
	localparam int RAMP_MAX = 256 * STEP_CNT + 8;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	bus_okay_a:
		assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
	latency_reg_a:
		assert property (hsel && htrans[1] && hready && !hwrite && haddr == 32'h0000_000C
			|=> hrdata == 32'h0000_0044) else $error("latency register wrong");
	power_supply_a:
		assert property (adc_power_on |-> $past(analog_supply && io_supply, 4))
			else $error("channels on without supplies");
	sample_pass_a:
		assert property (sample_in_valid && adc_power_on |=> sample_out_valid || !adc_power_on)
			else $error("sample dropped while powered");
	sample_src_a:
		assert property (sample_out_valid |-> $past(sample_in_valid))
			else $error("sample out without sample in");
	sleep_quiet_a:
		assert property (!adc_power_on && !$past(adc_power_on) |-> !sample_out_valid)
			else $error("sample out while asleep");
	irq_cause_a:
		assert property ($rose(general_output_pin) |-> adc_power_on)
			else $error("interrupt not on clock loss");
	irq_latch_a:
		assert property ((analog_supply && io_supply)[*4] ##0 $past(general_output_pin)
			|-> general_output_pin) else $error("interrupt cleared without power cycle");
	ramp_hold_a:
		assert property ($rose(general_output_pin) |-> adc_power_on[*8])
			else $error("channels off without ramp");
	// Cycles since the interrupt rose while channels stay up; a counter because
	// a full-length ramp is far longer than a delay range should span
	logic irq_q;
	logic [31:0] ramp_cnt;
	always_ff @(posedge clock) begin
		if (!rstn) begin
			irq_q <= 1'b0;
			ramp_cnt <= 32'h0000_0000;
		end else begin
			irq_q <= general_output_pin;
			if (general_output_pin && !irq_q) begin
				ramp_cnt <= 32'h0000_0001; // Interrupt just rose
			end else if (ramp_cnt != 32'h0000_0000 && adc_power_on) begin
				ramp_cnt <= ramp_cnt + 32'h0000_0001; // Still ramping
			end else begin
				ramp_cnt <= 32'h0000_0000; // Channels down, or no ramp
			end
		end
	end
	ramp_end_a:
		assert property (ramp_cnt <= 32'(RAMP_MAX))
			else $error("channels not powered down");
endmodule : psq_sequencer_chk
bind psq_sequencer psq_sequencer_chk #(.STEP_CNT(STEP_CNT)) chk_u (.clock(clock), .rstn(rstn),
	.analog_supply(analog_supply), .io_supply(io_supply), .sample_in_valid(sample_in_valid),
	.sample_out_valid(sample_out_valid), .adc_power_on(adc_power_on),
	.general_output_pin(general_output_pin), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

// *** tb.sv ***
// Self-checking bench for the power sequencer
`timescale 1ns/100ps
module tb import psq_pkg::*;;
	logic clock = 1'b0;
	logic rstn, analog_supply, io_supply, serial_format_select_pin, run, no_bit;
	logic [5:0] cfg; // Mode pins a..f
	logic bit_clock, frame_sync, sample_in_valid, sample_out_valid, adc_power_on;
	logic general_output_pin, hsel, hwrite, hready, hreadyout, hresp;
	psq_pair_t sample_in, sample_out;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	int n_errors = 0, checks = 0, k, i, sh;
	integer seed = 32'hD4A2E0E3;
	logic signed [23:0] xl, xr;
	psq_pair_t expq[$]; // Expected samples, oldest first
	always #2 clock = ~clock;
	assign hready = hreadyout;
	psq_sequencer #(.INIT_CNT(50), .WDOG_CNT(200), .STEP_CNT(2)) dut_u (.clock(clock),
		.rstn(rstn), .analog_supply(analog_supply), .io_supply(io_supply),
		.serial_format_select_pin(serial_format_select_pin), .mode_config_pin_a(cfg[5]),
		.mode_config_pin_b(cfg[4]), .mode_config_pin_c(cfg[3]), .mode_config_pin_d(cfg[2]),
		.mode_config_pin_e(cfg[1]), .mode_config_pin_f(cfg[0]), .bit_clock(bit_clock),
		.frame_sync(frame_sync), .sample_in_valid(sample_in_valid), .sample_in(sample_in),
		.sample_out_valid(sample_out_valid), .sample_out(sample_out),
		.adc_power_on(adc_power_on), .general_output_pin(general_output_pin), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
	psq_host host_u (.run(run), .no_bit(no_bit), .bit_clock(bit_clock), .frame_sync(frame_sync));
	// Compare and count
	task check(input string nm, input logic [47:0] e, input logic [47:0] s);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	// One single-word bus transfer, waiting on ready in both phases
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= a;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus
	// Verdict and end of run
	task stop_test;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	// Power cycle with a new format, settle pins, then wake with clocks
	task power_up(input logic f, input logic a);
		run <= 1'b0;
		rstn <= 1'b0;
		analog_supply <= 1'b0;
		io_supply <= 1'b0;
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		serial_format_select_pin <= f;
		io_supply <= 1'b1; // I/O first, analog later
		@(posedge clock);
		analog_supply <= 1'b1;
		repeat (60) @(posedge clock); // Init span
		cfg <= {a, 5'($random(seed))};
		bus(1'b0, 32'h0000_0004, 32'h0, rd);
		check("sleep status", 7'b0000011, rd[6:0]);
		run <= 1'b1;
		for (i = 0; i < 500 && adc_power_on !== 1'b1; i++) @(posedge clock);
		bus(1'b0, 32'h0000_0008, 32'h0, rd);
		check("mode pins", {f, a, cfg[4:0]}, rd[6:0]);
		check("powered", 1'b1, adc_power_on);
	endtask : power_up
	// Each filtered sample against the oldest note
	always @(posedge clock) begin
		if (sample_out_valid === 1'b1) begin
			if (expq.size() == 0) check("stray sample", 48'h0, 48'h1);
			else check("sample", expq.pop_front(), sample_out);
		end
	end
	// Hang guard, well past the expected run
	initial begin
		#100000;
		n_errors++;
		stop_test;
	end
	initial begin
		{rstn, analog_supply, io_supply, serial_format_select_pin, run, no_bit} = '0;
		{sample_in_valid, hsel, hwrite, htrans, haddr, hwdata, cfg, sample_in} = '0;
		hsize = 3'b010;
		// Cut-off: 12Hz allowed target I2S/LJ; refused for TDM and controller; default 1Hz
		for (k = 0; k < 4; k++) begin
			power_up(k != 2, k == 3);
			bus(1'b1, 32'h0000_0000, {31'h0, k != 1}, rd);
			bus(1'b0, 32'h0000_0000, 32'h0, rd);
			check("cut-off select", {31'h0, k != 1}, rd);
			sh = (k == 0) ? HPF_SHIFT_12HZ : HPF_SHIFT_1HZ;
			xl = 24'($random(seed));
			xr = 24'($random(seed));
			expq.push_back({xl, xr}); // First step passes whole
			expq.push_back({xl - (xl >>> sh), xr - (xr >>> sh)});
			for (i = 0; i < 2; i++) begin
				@(posedge clock);
				sample_in_valid <= 1'b1;
				sample_in <= {xl, xr};
			end
			@(posedge clock);
			sample_in_valid <= 1'b0;
			repeat (4) @(posedge clock);
			check("all samples out", 48'h0, expq.size());
			$display("filter test %0d done", k);
		end
		// Clocks stop: watchdog, interrupt, ramp, sleep
		run <= 1'b0;
		for (i = 0; i < 400 && general_output_pin !== 1'b1; i++) @(posedge clock);
		bus(1'b0, 32'h0000_0004, 32'h0, rd);
		check("stop status", 7'b1011110, rd[6:0]);
		for (i = 0; i < 700 && adc_power_on !== 1'b0; i++) @(posedge clock);
		bus(1'b0, 32'h0000_0004, 32'h0, rd);
		check("back to sleep", 3'b011, rd[2:0]);
		@(posedge clock);
		sample_in_valid <= 1'b1; // Asleep, so this one must be dropped
		@(posedge clock);
		sample_in_valid <= 1'b0;
		bus(1'b0, 32'h0000_0010, 32'h0, rd);
		check("unmapped read", 32'h0, rd);
		bus(1'b0, 32'h0000_000C, 32'h0, rd);
		check("latency", LL_DELAY_TENTHS, rd);
		run <= 1'b1;
		for (i = 0; i < 500 && adc_power_on !== 1'b1; i++) @(posedge clock);
		check("rewake", 2'b11, {adc_power_on, general_output_pin});
		$display("stop test done");
		// Frame sync without bit clock is a clock error
		no_bit <= 1'b1;
		for (i = 0; i < 1000 && adc_power_on !== 1'b0; i++) @(posedge clock);
		bus(1'b0, 32'h0000_0004, 32'h0, rd);
		check("error flag", 2'b11, {rd[5], rd[3]});
		analog_supply <= 1'b0; // Power cycle clears the latch
		repeat (8) @(posedge clock);
		check("irq cleared", 1'b0, general_output_pin);
		$display("error test done");
		stop_test;
	end
endmodule : tb
